/* rtl/scd_pkg.sv */
// Constants and types shared by the system clock source and divider block
package scd_pkg;

  // ****************************************************************
  // Register map (byte addresses on the Avalon-MM slave)
  // ****************************************************************
  localparam logic [7:0] ADDR_RUN_CFG     = 8'h00; // run_clock_config
  localparam logic [7:0] ADDR_RUN_CFG_EXT = 8'h04; // run_clock_config_ext
  localparam logic [7:0] ADDR_DSLP_CFG    = 8'h08; // deep_sleep_clock_config
  localparam logic [7:0] ADDR_GATE        = 8'h0c; // peripheral clock gates
  localparam logic [7:0] ADDR_STATUS      = 8'h10; // read-only state

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int OSC_SEL_LSB     = 4;   // osc_select [5:4], ext [6:4]
  localparam int CRYSTAL_SELECT_LSB        = 6;   // crystal_select [10:6]
  localparam int BYPASS_BIT      = 11;  // pll_bypass / pll_bypass_ext
  localparam int PWRDN_BIT       = 13;  // PLL power-down
  localparam int DIV_EN_BIT      = 22;  // divider_enable (base only)
  localparam int SYSTEM_DIVISOR_LSB      = 23;  // system_divisor [26:23], ext [28:23]
  localparam int OVERRIDE_BIT    = 31;  // ext_config_override
  localparam int ST_LOCK_BIT     = 0;
  localparam int ST_PLL_BIT      = 1;
  localparam int ST_SRC_LSB      = 2;   // active source [4:2]
  localparam int ST_DSLP_BIT     = 5;
  localparam int ST_RATIO_LSB    = 8;   // active ratio [14:8]

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] RST_OSC_SEL     = 2'h1;  // internal oscillator
  localparam logic [2:0] RST_OSC_SEL_EXT = 3'h1;
  localparam logic [4:0] RST_CRYSTAL_SELECT        = 5'h0b;
  localparam logic [3:0] RST_SYSTEM_DIVISOR      = 4'hf;  // /16, 12.5 MHz on PLL
  localparam logic [5:0] RST_SYSTEM_DIVISOR_EXT  = 6'h0f;
  localparam logic [6:0] RST_RATIO       = 7'h01;

  // ****************************************************************
  // Source encodings of the oscillator select fields
  // ****************************************************************
  localparam logic [2:0] SRC_MAIN   = 3'h0;
  localparam logic [2:0] SRC_INT    = 3'h1;
  localparam logic [2:0] SRC_INT_D4 = 3'h2;
  localparam logic [2:0] SRC_LF     = 3'h3;
  localparam logic [2:0] SRC_RTC    = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          RELOCK_PRESET = 32'h1200; // main osc ticks
  localparam logic [1:0]  INT_D4_LAST   = 2'h3;     // divide by four
  localparam int          PLL_MHZ       = 400;
  localparam int          ADC_MHZ       = 16;
  localparam logic [4:0]  ADC_LAST      = 5'(PLL_MHZ / ADC_MHZ - 1);

  // PLL readiness sequencing
  typedef enum logic [1:0] {
    PLL_OFF    = 2'b00,
    PLL_WAIT   = 2'b01,
    PLL_LOCKED = 2'b10
  } scd_pll_t;

endpackage

/* rtl/scd_div_if.sv */
// Link between the clock controller and its glitch-free divider
`timescale 1ns/100ps
interface scd_div_if;
  logic       tick;   // Selected source edge, one cycle
  logic [6:0] ratio;  // Requested divide ratio, 1..64
  logic       pulse;  // Divided clock edge, one cycle
  logic [6:0] active; // Ratio now in use

  modport ctrl (output tick, output ratio, input pulse, input active);
  modport div  (input tick, input ratio, output pulse, output active);
endinterface

/* rtl/scd_divider.sv */
// Programmable divider of source ticks into system clock edges
`timescale 1ns/100ps
module scd_divider
  import scd_pkg::*;
(
  input  wire logic MCLK,
  input  wire logic RSTN,
  scd_div_if.div    dv
);

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [6:0] ratio_l;
  logic [6:0] next_ratio_l;
  logic       pulse;
  logic       next_pulse;

  // Count source ticks; new ratio only taken at the wrap point
  always_comb begin
    next_cnt     = cnt;
    next_ratio_l = ratio_l;
    next_pulse   = 1'b0;
    if (dv.tick) begin
      if (cnt + 7'h01 >= ratio_l) begin
        next_cnt     = 7'h00;
        next_pulse   = 1'b1;
        next_ratio_l = (dv.ratio == 7'h00) ? 7'h01 : dv.ratio;
      end else begin
        next_cnt = cnt + 7'h01;
      end
    end
  end

  // State registers
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      cnt     <= 7'h00;
      ratio_l <= RST_RATIO;
      pulse   <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      ratio_l <= next_ratio_l;
      pulse   <= next_pulse;
    end
  end

  assign dv.pulse  = pulse;
  assign dv.active = ratio_l;

endmodule

/* rtl/scd_clock_ctrl.sv */
// System clock source selection, PLL readiness and clock distribution
`timescale 1ns/100ps
// Overview of operation
// - Internal oscillator drives clock out of reset
// - PLL and internal/4 are selectable too
// - Select codes 0 main,1 int,2 int/4,3 30k
// - Extended select 0x7 picks real-time oscillator
// - PLL only from main oscillator, bypass cleared
// - Override bit makes extended fields govern
// - Bypass chooses PLL or oscillator for divisor
// - PLL output halved before the divisor
// - Divisor equals field plus one, 1..16
// - Divisor resets to /16; 0..2 reserved on PLL
// - On oscillator: divider off passes source; 0,1 give /2
// - Extended divisor six bits, up to /64
// - Extended bypass acts like base bypass
// - 16 MHz converter clock from PLL while PLL powered up
// - Each peripheral has its own clock gate
// - Deep sleep takes deep-sleep source and divisor
// - Relock countdown on main osc before PLL
// - A changed crystal code or PLL power-up forces relock
module scd_clock_ctrl
  import scd_pkg::*;
#(
  parameter int NPERIPH      = 8,
  parameter int RELOCK_TICKS = RELOCK_PRESET
)(
  input  wire logic               MCLK,
  input  wire logic               RSTN,
  input  wire logic [7:0]         AVS_ADDRESS,
  input  wire logic               AVS_READ,
  input  wire logic               AVS_WRITE,
  input  wire logic [31:0]        AVS_WRITEDATA,
  input  wire logic [3:0]         AVS_BYTEENABLE,
  output logic [31:0]             AVS_READDATA,
  output logic                    AVS_WAITREQUEST,
  input  wire logic               MAIN_OSC_CLK,
  input  wire logic               INT_OSC_CLK,
  input  wire logic               LF_OSC_CLK,
  input  wire logic               RTC_OSC_CLK,
  input  wire logic               PLL_CLK,
  input  wire logic               DEEP_SLEEP,
  output logic                    SYSTEM_CLOCK_EN,
  output logic                    ADC_CLK_EN,
  output logic [NPERIPH-1:0]      PERIPH_CLK_EN,
  output logic                    PLL_PWRDN
);

  // ****************************************************************
  // Input synchronisers and edge detection
  // ****************************************************************
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] sync3;
  logic       main_tick;
  logic       int_tick;
  logic       lf_tick;
  logic       rtc_tick;
  logic       pll_tick;
  logic       dslp;

  // Oscillators are asynchronous to MCLK; only sync2 and sync3 feed logic
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 6'h00;
    end else begin
      sync1 <= {DEEP_SLEEP, PLL_CLK, RTC_OSC_CLK, LF_OSC_CLK,
                INT_OSC_CLK, MAIN_OSC_CLK};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Rising edges become one-cycle ticks
  assign main_tick = sync2[0] & ~sync3[0];
  assign int_tick  = sync2[1] & ~sync3[1];
  assign lf_tick   = sync2[2] & ~sync3[2];
  assign rtc_tick  = sync2[3] & ~sync3[3];
  assign pll_tick  = sync2[4] & ~sync3[4];
  assign dslp      = sync2[5];

  // ****************************************************************
  // Configuration registers and Avalon-MM slave
  // ****************************************************************
  logic [31:0]        run_cfg;
  logic [31:0]        run_cfg_ext;
  logic [31:0]        dslp_cfg;
  logic [NPERIPH-1:0] gate;
  logic [31:0]        next_run_cfg;
  logic [31:0]        next_run_cfg_ext;
  logic [31:0]        next_dslp_cfg;
  logic [NPERIPH-1:0] next_gate;
  logic [31:0]        next_rdata;
  logic               next_wait;
  logic               crystal_select_changed;
  logic [31:0]        status;
  logic               wr_go;

  // Byte-enable lanes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Merge write data under the byte-enable mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    merge = (old & ~lane_mask(be)) | (wd & lane_mask(be));
  endfunction

  // A write lands at the edge where waitrequest is low
  assign wr_go = AVS_WRITE & ~AVS_WAITREQUEST;

  // One wait state: answer is registered, then waitrequest drops
  always_comb begin
    next_run_cfg     = run_cfg;
    next_run_cfg_ext = run_cfg_ext;
    next_dslp_cfg    = dslp_cfg;
    next_gate        = gate;
    next_rdata       = AVS_READDATA;
    next_wait        = ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
    crystal_select_changed     = 1'b0;
    if (wr_go) begin
      if (AVS_ADDRESS == ADDR_RUN_CFG) begin
        next_run_cfg = merge(run_cfg, AVS_WRITEDATA, AVS_BYTEENABLE);
        crystal_select_changed = next_run_cfg[CRYSTAL_SELECT_LSB +: 5] !=
                       run_cfg[CRYSTAL_SELECT_LSB +: 5];
      end else if (AVS_ADDRESS == ADDR_RUN_CFG_EXT) begin
        next_run_cfg_ext = merge(run_cfg_ext, AVS_WRITEDATA,
                                 AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == ADDR_DSLP_CFG) begin
        next_dslp_cfg = merge(dslp_cfg, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == ADDR_GATE) begin
        next_gate = NPERIPH'(merge(32'(gate), AVS_WRITEDATA,
                                   AVS_BYTEENABLE));
      end
    end
    if (AVS_READ & AVS_WAITREQUEST) begin
      if (AVS_ADDRESS == ADDR_RUN_CFG) begin
        next_rdata = run_cfg;
      end else if (AVS_ADDRESS == ADDR_RUN_CFG_EXT) begin
        next_rdata = run_cfg_ext;
      end else if (AVS_ADDRESS == ADDR_DSLP_CFG) begin
        next_rdata = dslp_cfg;
      end else if (AVS_ADDRESS == ADDR_GATE) begin
        next_rdata = 32'(gate);
      end else if (AVS_ADDRESS == ADDR_STATUS) begin
        next_rdata = status;
      end else begin
        next_rdata = 32'h0000_0000; // Unmapped reads as zero
      end
    end
  end

  // Register file; reset picks internal oscillator, PLL off, divider off (divisor field /16)
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      run_cfg <= (32'(RST_OSC_SEL) << OSC_SEL_LSB)
               | (32'(RST_CRYSTAL_SELECT) << CRYSTAL_SELECT_LSB)
               | (32'h1 << BYPASS_BIT) | (32'h1 << PWRDN_BIT)
               | (32'(RST_SYSTEM_DIVISOR) << SYSTEM_DIVISOR_LSB);
      run_cfg_ext <= (32'(RST_OSC_SEL_EXT) << OSC_SEL_LSB)
                   | (32'h1 << BYPASS_BIT) | (32'h1 << PWRDN_BIT)
                   | (32'(RST_SYSTEM_DIVISOR_EXT) << SYSTEM_DIVISOR_LSB);
      dslp_cfg        <= (32'(RST_OSC_SEL_EXT) << OSC_SEL_LSB)
                       | (32'(RST_SYSTEM_DIVISOR_EXT) << SYSTEM_DIVISOR_LSB);
      gate            <= '0;
      AVS_READDATA    <= 32'h0000_0000;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      run_cfg         <= next_run_cfg;
      run_cfg_ext     <= next_run_cfg_ext;
      dslp_cfg        <= next_dslp_cfg;
      gate            <= next_gate;
      AVS_READDATA    <= next_rdata;
      AVS_WAITREQUEST <= next_wait;
    end
  end

  // ****************************************************************
  // Effective configuration
  // ****************************************************************
  logic       eff_bypass;
  logic       eff_pwrdn;
  logic       eff_diven;
  logic [2:0] eff_osc;
  logic [5:0] eff_div;
  logic       use_pll;
  logic [6:0] ratio;
  scd_pll_t   pll_st;

  // Pick which register governs, then the deep-sleep override
  always_comb begin
    if (run_cfg_ext[OVERRIDE_BIT]) begin
      eff_bypass = run_cfg_ext[BYPASS_BIT];
      eff_pwrdn  = run_cfg_ext[PWRDN_BIT];
      eff_osc    = run_cfg_ext[OSC_SEL_LSB +: 3];
      eff_div    = run_cfg_ext[SYSTEM_DIVISOR_LSB +: 6];
    end else begin
      eff_bypass = run_cfg[BYPASS_BIT];
      eff_pwrdn  = run_cfg[PWRDN_BIT];
      eff_osc    = {1'b0, run_cfg[OSC_SEL_LSB +: 2]};
      eff_div    = {2'b00, run_cfg[SYSTEM_DIVISOR_LSB +: 4]};
    end
    eff_diven = run_cfg[DIV_EN_BIT];
    if (dslp) begin
      eff_bypass = 1'b1;
      eff_pwrdn  = 1'b1;
      eff_diven  = 1'b1;
      eff_osc    = dslp_cfg[OSC_SEL_LSB +: 3];
      eff_div    = dslp_cfg[SYSTEM_DIVISOR_LSB +: 6];
    end
    use_pll = ~eff_bypass & (eff_osc == SRC_MAIN) & (pll_st == PLL_LOCKED);
    if (use_pll) begin
      ratio = {1'b0, eff_div} + 7'h01;
    end else if (eff_diven) begin
      // codes 0 and 1 give /2
      ratio = (eff_div == 6'h00) ? 7'h02 : {1'b0, eff_div} + 7'h01;
    end else begin
      ratio = 7'h01;
    end
  end

  // ****************************************************************
  // PLL readiness countdown on the main oscillator
  // ****************************************************************
  scd_pll_t   next_pll_st;
  logic [15:0] relock;
  logic [15:0] next_relock;
  logic        pwrdn_d;
  logic        next_pwrdn_d;

  // Restart on crystal change or power-up; only main ticks count down
  always_comb begin
    next_pll_st  = pll_st;
    next_relock  = relock;
    next_pwrdn_d = eff_pwrdn;
    case (pll_st)
      PLL_OFF: begin
        if (!eff_pwrdn) begin
          next_pll_st = PLL_WAIT;
          next_relock = 16'(RELOCK_TICKS);
        end
      end
      PLL_WAIT: begin
        if (main_tick && relock != 16'h0000) begin
          next_relock = relock - 16'h0001;
        end
        if (relock == 16'h0000) begin
          next_pll_st = PLL_LOCKED;
        end
      end
      PLL_LOCKED: begin
        next_pll_st = PLL_LOCKED;
      end
      default: begin
        next_pll_st = PLL_OFF;
      end
    endcase
    if (crystal_select_changed && !eff_pwrdn) begin
      next_pll_st = PLL_WAIT;
      next_relock = 16'(RELOCK_TICKS);
    end
    if (eff_pwrdn) begin
      next_pll_st = PLL_OFF;
    end
  end

  // Readiness registers
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      pll_st  <= PLL_OFF;
      relock  <= 16'h0000;
      pwrdn_d <= 1'b1;
    end else begin
      pll_st  <= next_pll_st;
      relock  <= next_relock;
      pwrdn_d <= next_pwrdn_d;
    end
  end

  // ****************************************************************
  // Source prescalers and the clock-tree multiplexer
  // ****************************************************************
  logic [1:0] int_cnt;
  logic [1:0] next_int_cnt;
  logic       pll_half;
  logic       next_pll_half;
  logic [4:0] adc_cnt;
  logic [4:0] next_adc_cnt;
  logic       adc_en;
  logic       next_adc_en;
  logic       src_tick;
  logic       int_d4_tick;
  logic       raw_tick;
  logic [3:0] src_key;
  logic [3:0] next_src_key;
  logic       skip;
  logic       next_skip;
  scd_div_if  dvi ();

  assign int_d4_tick = int_tick & (int_cnt == INT_D4_LAST);

  // Prescalers; the converter clock ignores the system divisor
  always_comb begin
    next_int_cnt  = int_tick ? int_cnt + 2'h1 : int_cnt;
    next_pll_half = pll_tick ? ~pll_half : pll_half;
    next_adc_cnt  = adc_cnt;
    next_adc_en   = 1'b0;
    if (pll_tick && !eff_pwrdn) begin
      next_adc_cnt = (adc_cnt == ADC_LAST) ? 5'h00 : adc_cnt + 5'h01;
      next_adc_en  = (adc_cnt == ADC_LAST);
    end
    // drop first tick after switch
    // A source switch can land just after an old tick; dropping the
    // new source's first tick buys one full new period of spacing
    next_skip = skip;
    if (next_src_key != src_key) begin
      next_skip = 1'b1;
    end else if (raw_tick) begin
      next_skip = 1'b0;
    end
  end

  // Prescaler registers
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      int_cnt  <= 2'h0;
      pll_half <= 1'b0;
      adc_cnt  <= 5'h00;
      adc_en   <= 1'b0;
      src_key  <= {1'b0, SRC_INT};
      skip     <= 1'b0;
    end else begin
      int_cnt  <= next_int_cnt;
      pll_half <= next_pll_half;
      adc_cnt  <= next_adc_cnt;
      adc_en   <= next_adc_en;
      src_key  <= next_src_key;
      skip     <= next_skip;
    end
  end

  always_comb begin
    case (eff_osc)
      SRC_MAIN:   src_tick = main_tick;
      SRC_INT:    src_tick = int_tick;
      SRC_INT_D4: src_tick = int_d4_tick;
      SRC_LF:     src_tick = lf_tick;
      SRC_RTC:    src_tick = rtc_tick;
      default:    src_tick = int_tick;
    endcase
  end

  assign raw_tick     = use_pll ? (pll_tick & pll_half) : src_tick;
  assign next_src_key = {use_pll, eff_osc};
  assign dvi.tick     = raw_tick & ~skip & (next_src_key == src_key);
  assign dvi.ratio    = ratio;

  scd_divider u_div (
    .MCLK (MCLK),
    .RSTN (RSTN),
    .dv   (dvi.div)
  );

  // ****************************************************************
  // Gated outputs and wake sequencing
  // ****************************************************************
  logic               run_ok;
  logic               next_run_ok;
  logic [NPERIPH-1:0] next_periph;

  // After deep sleep, gates stay shut until one system clock edge under run settings
  always_comb begin
    next_run_ok = run_ok;
    if (dslp) begin
      next_run_ok = 1'b0;
    end else if (dvi.pulse) begin
      next_run_ok = 1'b1;
    end
  end

  for (genvar i = 0; i < NPERIPH; i++) begin : g_gate
    assign next_periph[i] = dvi.pulse & gate[i] & run_ok;
  end

  // Status word read back by software
  assign status = (32'(pll_st == PLL_LOCKED) << ST_LOCK_BIT)
                | (32'(use_pll) << ST_PLL_BIT)
                | (32'(eff_osc) << ST_SRC_LSB)
                | (32'(dslp) << ST_DSLP_BIT)
                | (32'(dvi.active) << ST_RATIO_LSB);

  // Every output leaves from a flop
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      run_ok        <= 1'b1;
      SYSTEM_CLOCK_EN     <= 1'b0;
      ADC_CLK_EN    <= 1'b0;
      PERIPH_CLK_EN <= '0;
      PLL_PWRDN     <= 1'b1;
    end else begin
      run_ok        <= next_run_ok;
      SYSTEM_CLOCK_EN     <= dvi.pulse;
      ADC_CLK_EN    <= adc_en;
      PERIPH_CLK_EN <= next_periph;
      PLL_PWRDN     <= pwrdn_d;
    end
  end

endmodule

/* bench/scd_osc_model.sv */
// Behavioural oscillators and PLL on the far side of the clock controller
`timescale 1ns/100ps
module scd_osc_model (
  input  wire logic pll_pwrdn,
  output logic      main_clk,
  output logic      int_clk,
  output logic      lf_clk,
  output logic      rtc_clk,
  output logic      pll_clk
);
  // Edges sit 2 ns before a rising system clock edge, so no race
  // main oscillator stable from start
  initial begin
    main_clk = 1'b0;
    #3;
    forever #30 main_clk = ~main_clk;
  end

  // Internal, low-frequency and real-time sources run free
  initial begin
    int_clk = 1'b0;
    lf_clk = 1'b0;
    rtc_clk = 1'b0;
    #3;
    fork
      forever #40 int_clk = ~int_clk;
      forever #100 lf_clk = ~lf_clk;
      forever #70 rtc_clk = ~rtc_clk;
    join
  end

  // Powered-down PLL drives no output, so its line stands low
  initial begin
    pll_clk = 1'b0;
    #3;
    forever begin
      #40;
      pll_clk = pll_pwrdn ? 1'b0 : ~pll_clk;
    end
  end
endmodule

/* bench/scd_clock_ctrl_sva.sv */
// Port-level assertions of the clock controller
`timescale 1ns/100ps
module scd_clock_ctrl_sva
  import scd_pkg::*;
#(
  parameter int NPERIPH = 8
)(
  input wire logic               MCLK,
  input wire logic               RSTN,
  input wire logic [7:0]         AVS_ADDRESS,
  input wire logic               AVS_READ,
  input wire logic               AVS_WRITE,
  input wire logic [31:0]        AVS_READDATA,
  input wire logic               AVS_WAITREQUEST,
  input wire logic               DEEP_SLEEP,
  input wire logic               SYSTEM_CLOCK_EN,
  input wire logic               ADC_CLK_EN,
  input wire logic [NPERIPH-1:0] PERIPH_CLK_EN,
  input wire logic               PLL_PWRDN
);
  // One domain only, so clock and reset are given once
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  // Decoded register places
  logic mapped;
  assign mapped = AVS_ADDRESS inside {ADDR_RUN_CFG, ADDR_RUN_CFG_EXT,
                                      ADDR_DSLP_CFG, ADDR_GATE, ADDR_STATUS};

  a_rst_state: assert property ($rose(RSTN) |->
    AVS_WAITREQUEST && PLL_PWRDN && !SYSTEM_CLOCK_EN)
    else $error("outputs not at rest after reset");
  a_bus_answer: assert property ((AVS_READ || AVS_WRITE) &&
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  a_bus_single: assert property (!AVS_WAITREQUEST |=>
    AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_hole_zero: assert property (AVS_READ && !AVS_WAITREQUEST &&
    !mapped |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_clk_spacing: assert property (SYSTEM_CLOCK_EN |=>
    !SYSTEM_CLOCK_EN [*3])
    else $error("system clock edges too close");
  a_gate_follow: assert property (|PERIPH_CLK_EN |-> SYSTEM_CLOCK_EN)
    else $error("peripheral edge without system edge");
  a_adc_spacing: assert property (ADC_CLK_EN |=>
    !ADC_CLK_EN [*8])
    else $error("converter edges too close");
  a_sleep_pll: assert property (DEEP_SLEEP && $past(DEEP_SLEEP, 6)
    |-> PLL_PWRDN)
    else $error("PLL powered in deep sleep");
endmodule

bind scd_clock_ctrl scd_clock_ctrl_sva #(.NPERIPH(NPERIPH)) chk_u (
  .MCLK(MCLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .DEEP_SLEEP(DEEP_SLEEP), .SYSTEM_CLOCK_EN(SYSTEM_CLOCK_EN),
  .ADC_CLK_EN(ADC_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
  .PLL_PWRDN(PLL_PWRDN));

/* bench/scd_clock_ctrl_tb.sv */
// Self-checking bench of the system clock source and divider
`timescale 1ns/100ps
module scd_clock_ctrl_tb
  import scd_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        deep_sleep = 1'b0;
  logic        main_clk, int_clk, lf_clk, rtc_clk, pll_clk;
  logic        system_clock_en, adc_clk_en, pll_pwrdn;
  logic [7:0]  periph_clk_en;
  logic [7:0]  gate = 8'h00;
  logic [31:0] rd;
  int          miscompares = 0;
  int          compares = 0;

  // 100 MHz system clock
  always #5 mclk = ~mclk;

  scd_clock_ctrl #(.NPERIPH(8), .RELOCK_TICKS(8)) dut_u (
    .MCLK(mclk), .RSTN(rstn), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .MAIN_OSC_CLK(main_clk), .INT_OSC_CLK(int_clk), .LF_OSC_CLK(lf_clk),
    .RTC_OSC_CLK(rtc_clk), .PLL_CLK(pll_clk), .DEEP_SLEEP(deep_sleep),
    .SYSTEM_CLOCK_EN(system_clock_en), .ADC_CLK_EN(adc_clk_en),
    .PERIPH_CLK_EN(periph_clk_en), .PLL_PWRDN(pll_pwrdn));

  scd_osc_model osc_u (
    .pll_pwrdn(pll_pwrdn), .main_clk(main_clk), .int_clk(int_clk),
    .lf_clk(lf_clk), .rtc_clk(rtc_clk), .pll_clk(pll_clk));

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  // A wait that runs out ends the run at once
  task automatic hang(input string nm);
    $display("Error %s expected answer seen timeout", nm);
    miscompares++;
    report_and_stop();
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) hang("bus");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Crystal code stays at its default: no relock, legal PLL reference
  // crystal code kept
  function automatic logic [31:0] base(input logic [1:0] o, input logic b,
      input logic p, input logic d, input logic [3:0] v);
    return {5'h0, v, d, 8'h0, p, 1'b0, b, RST_CRYSTAL_SELECT, o, 4'h0};
  endfunction

  function automatic logic [31:0] ext(input logic [2:0] o, input logic b,
      input logic p, input logic [5:0] v, input logic ov);
    return {ov, 2'h0, v, 9'h0, p, 1'b0, b, 4'h0, o, 4'h0};
  endfunction

  // Cycles up to the next pulse of the system or converter clock
  task automatic gap(input logic adc, output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while ((adc ? adc_clk_en : system_clock_en) !== 1'b1 && c < 3000);
    if (c >= 3000) hang("clock pulse");
  endtask

  // Lets a change settle, then measures one system clock period
  task automatic per(input string nm, input int exp, input logic g);
    int c;
    repeat (5) gap(1'b0, c);
    gap(1'b0, c);
    check(nm, 32'(exp), 32'(c));
    if (g) check("gates", {24'h0, gate}, {24'h0, periph_clk_en});
  endtask

  task automatic t_reset();
    bus(1'b0, ADDR_RUN_CFG, 32'h0);
    check("run cfg", base(RST_OSC_SEL, 1, 1, 0, RST_SYSTEM_DIVISOR), rd);
    bus(1'b0, ADDR_RUN_CFG_EXT, 32'h0);
    check("ext cfg", ext(RST_OSC_SEL_EXT, 1, 1, RST_SYSTEM_DIVISOR_EXT, 0), rd);
    bus(1'b0, ADDR_DSLP_CFG, 32'h0);
    check("sleep cfg", ext(RST_OSC_SEL_EXT, 0, 0, RST_SYSTEM_DIVISOR_EXT, 0), rd);
    bus(1'b1, ADDR_STATUS, 32'hffffffff);
    bus(1'b1, 8'h14, 32'hffffffff);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status", {17'h0, RST_RATIO, 3'h0, SRC_INT, 2'h0}, rd);
    bus(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h0, rd);
    per("reset clock", 8, 1'b0);
    $display("reset test done");
  endtask

  task automatic t_source();
    int e [4] = '{6, 8, 32, 20};
    bus(1'b1, ADDR_GATE, 32'h5a);
    gate = 8'h5a;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_RUN_CFG, base(2'(i), 1, 1, 0, 4'hf));
      per("source", e[i], 1'b1);
    end
    $display("source test done");
  endtask

  task automatic t_divisor();
    logic [3:0] v [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
    int         e [4] = '{16, 16, 32, 128};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_RUN_CFG, base(SRC_INT[1:0], 1, 1, 1, v[i]));
      per("divisor", e[i], 1'b1);
    end
    $display("divisor test done");
  endtask

  task automatic t_ext();
    bus(1'b1, ADDR_RUN_CFG_EXT, ext(SRC_RTC, 1, 1, 6'h01, 1));
    per("rtc source", 28, 1'b1);
    bus(1'b1, ADDR_RUN_CFG_EXT, ext(SRC_MAIN, 1, 1, 6'h3f, 1));
    per("ext divisor", 384, 1'b1);
    $display("ext test done");
  endtask

  task automatic t_pll();
    int c;
    bus(1'b1, ADDR_RUN_CFG_EXT, ext(SRC_MAIN, 0, 0, 6'h03, 1));
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("early lock", 32'h0, {31'h0, rd[ST_LOCK_BIT]});
    per("pll clock", 64, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("pll status", 32'h3, {30'h0, rd[1:0]});
    gap(1'b1, c);
    gap(1'b1, c);
    check("adc period", 32'd200, 32'(c));
    $display("pll test done");
  endtask

  task automatic t_sleep();
    int c;
    deep_sleep <= 1'b1;
    repeat (8) @(posedge mclk);
    check("sleep pll off", 32'h1, {31'h0, pll_pwrdn});
    per("sleep clock", 128, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("sleep flag", 32'h1, {31'h0, rd[ST_DSLP_BIT]});
    deep_sleep <= 1'b0;
    gap(1'b0, c);
    check("wake gates", 32'h0, {24'h0, periph_clk_en});
    per("wake clock", 64, 1'b1);
    $display("sleep test done");
  endtask

  // Main sequence: reset held four cycles, then every test in turn
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_source();
    t_divisor();
    t_ext();
    t_pll();
    t_sleep();
    report_and_stop();
  end
endmodule
